/* File: design/sdr_core.sv */
// Command core of a four-bank synchronous DRAM, behind its pins.
// Assumes pins are synchronous to clk and the array answers in the cycle.
// Summary of operation
// - One mode set loads all fields; whole register is replaced.
// - Mode set decoded on all-low command; fields from address and bank.
// - Read latency programmable to two or three clocks.
// - Address 0..3 burst fields, 7..12 and bank pins operation mode.
// - Burst length 1, 2, 4 or 8.
// - Single-write mode: reads full burst, writes one word.
// - Sequential order increments, wrapping in the aligned block.
// - Interleave order is start column XOR beat count.
// - Page 2048, 1024 or 512 columns by width; upper bits ignored.
// - Activate: CS, RAS low, CAS, WE high; bank and row taken.
// - Bank pins binary, first pin least significant.
// - Column command: RAS high, CAS low; WE picks read or write.
// - A new column command restarts the burst at the new column.
// - Interrupted read data runs until the new read latency elapses.
// - Read decoded on CS, CAS low, RAS, WE high; data after latency.
// - DQM: read output enable two clocks late, write mask immediate.
// - Chip select high ignores commands; running work continues.
`timescale 1ns/1ps
`default_nettype none
`include "sdr_map.svh"
module sdr_core
(
  // Clock, reset, clock enable
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             cke,
  // Command pins
  input  wire logic             cs_n,
  input  wire logic             ras_n,
  input  wire logic             cas_n,
  input  wire logic             we_n,
  input  wire logic [1:0]       ba,
  input  wire logic [12:0]      addr,
  input  wire logic             dqm,
  // Data pins
  input  wire logic [15:0]      dq_i,
  output logic      [15:0]      dq_o,
  output logic                  dq_oe,
  // Organisation select
  input  wire sdr_pkg::sdr_org_e org,
  // Array port
  output logic      [1:0]       arr_bank,
  output logic      [12:0]      arr_row,
  output logic      [10:0]      arr_col,
  output logic                  arr_rd,
  output logic                  arr_wr,
  output logic      [15:0]      arr_wdata,
  input  wire logic [15:0]      arr_rdata,
  // Status
  output logic      [14:0]      mode_q,
  output logic      [3:0]       bank_open
);
  typedef struct packed
  {
    logic [14:0]       mode;
    logic [3:0]        open;
    logic [3:0][12:0]  row;
    logic [1:0]        bank;
    logic [1:0]        abank;
    logic [10:0]       col;
    logic              rd;
    logic              wr;
    logic [15:0]       wdata;
    logic [2:0][15:0]  pd;
    logic [2:0]        pv;
    logic [2:0]        dm;
  } sdr_core_s;

  sdr_core_s q_ff;
  sdr_core_s nxt_q;
  sdr_pkg::sdr_cmd_e cmd;
  logic [3:0] rd_len;
  logic       cl3;
  logic       out_vld;
  sdr_burst_if bif ();

  // Command from pin levels; chip select high reads as no command
  function automatic sdr_pkg::sdr_cmd_e decode
  (
    input logic cs,
    input logic ras,
    input logic cas,
    input logic we
  );
    case ({cs, ras, cas, we})
      4'h3:    decode = sdr_pkg::CMD_ACT;
      4'h5:    decode = sdr_pkg::CMD_RD;
      4'h4:    decode = sdr_pkg::CMD_WR;
      4'h2:    decode = sdr_pkg::CMD_PRE;
      4'h0:    decode = sdr_pkg::CMD_MRS;
      4'h1:    decode = sdr_pkg::CMD_REF;
      default: decode = sdr_pkg::CMD_NOP;
    endcase
  endfunction : decode

  // Column bits that exist for the chosen width
  function automatic logic [10:0] col_of
  (
    input sdr_pkg::sdr_org_e o,
    input logic [12:0]       a
  );
    case (o)
      sdr_pkg::ORG_X8:  col_of = {1'b0, a[9:0]};
      sdr_pkg::ORG_X16: col_of = {2'h0, a[8:0]};
      default:          col_of = {a[11], a[9:0]};
    endcase
  endfunction : col_of

  assign cmd = decode(cs_n, ras_n, cas_n, we_n);

  always_comb
  begin
    case (q_ff.mode[`SDR_BL_LSB +: 3])
      `SDR_BL_2: rd_len = 4'h2;
      `SDR_BL_4: rd_len = 4'h4;
      `SDR_BL_8: rd_len = 4'h8;
      default:   rd_len = 4'h1;
    endcase
  end

  // latency select; codes other than two act as three
  assign cl3 = q_ff.mode[`SDR_CL_LSB +: 3] != `SDR_CL_2;

  // Burst request to the generator
  assign bif.ce = cke;
  assign bif.go = (cmd == sdr_pkg::CMD_RD) || (cmd == sdr_pkg::CMD_WR);
  assign bif.is_wr = cmd == sdr_pkg::CMD_WR;
  assign bif.start = col_of(org, addr);
  assign bif.len = (bif.is_wr && q_ff.mode[`SDR_WB_BIT]) ? 4'h1 : rd_len;
  // order bit taken from address bit 3
  assign bif.ilv = q_ff.mode[`SDR_BT_BIT];

  sdr_burst u_burst
  (
    .clk  (clk),
    .srst (srst),
    .bif  (bif)
  );

  // Command effects and the array and output pipelines
  always_comb
  begin
    nxt_q = q_ff;
    case (cmd)
      sdr_pkg::CMD_MRS:
        nxt_q.mode = {ba, addr};
      sdr_pkg::CMD_ACT:
      begin
        nxt_q.open[ba] = 1'b1;
        nxt_q.row[ba] = addr;
      end
      sdr_pkg::CMD_PRE:
        if (addr[`SDR_AP_BIT])
          nxt_q.open = 4'h0;
        else
          nxt_q.open[ba] = 1'b0;
      sdr_pkg::CMD_RD, sdr_pkg::CMD_WR:
        nxt_q.bank = ba;
      default:
        nxt_q.bank = q_ff.bank;
    endcase
    nxt_q.abank = bif.go ? ba : q_ff.bank;
    nxt_q.col = bif.col;
    nxt_q.rd = bif.vld && !bif.wr;
    nxt_q.wr = bif.vld && bif.wr && !dqm;
    nxt_q.wdata = dq_i;
    // old data keeps flowing through the pipe
    nxt_q.pd = {q_ff.pd[1:0], arr_rdata};
    nxt_q.pv = {q_ff.pv[1:0], q_ff.rd};
    nxt_q.dm = {q_ff.dm[1:0], dqm};
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q_ff <= '0;
      q_ff.mode <= `SDR_MODE_RST;
      q_ff.dm <= 3'h7;
    end
    else if (cke)
      q_ff <= nxt_q;
  end

  assign out_vld = cl3 ? q_ff.pv[2] : q_ff.pv[1];
  assign dq_o = cl3 ? q_ff.pd[2] : q_ff.pd[1];
  // Mask sampled two edges back; lines up with a same-edge read only at latency two
  assign dq_oe = out_vld && !q_ff.dm[2];

  // Outputs straight from the state register
  assign arr_bank = q_ff.abank;
  assign arr_row = q_ff.row[q_ff.abank];
  assign arr_col = q_ff.col;
  assign arr_rd = q_ff.rd;
  assign arr_wr = q_ff.wr;
  assign arr_wdata = q_ff.wdata;
  assign mode_q = q_ff.mode;
  assign bank_open = q_ff.open;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  read_lat_two_a: assert property (
    (cmd == sdr_pkg::CMD_RD && cke && !cl3) ##1 cke ##1 cke |=> out_vld)
    else $error("read data missing at latency two");
  read_lat_three_a: assert property (
    (cmd == sdr_pkg::CMD_RD && cke && cl3) ##1 cke[*3] |=> out_vld)
    else $error("read data missing at latency three");
  mode_load_a: assert property (
    cmd == sdr_pkg::CMD_MRS && cke |=> mode_q == {$past(ba), $past(addr)})
    else $error("mode register not loaded");
  bank_activate_a: assert property (
    cmd == sdr_pkg::CMD_ACT && cke |=> bank_open[$past(ba)]
    && q_ff.row[$past(ba)] == $past(addr))
    else $error("activated bank not open");
  deselect_hold_a: assert property (
    cs_n && cke |=> $stable(mode_q) && $stable(bank_open))
    else $error("deselected command took effect");
  read_mask_a: assert property (
    (dqm && cke) ##1 cke ##1 cke |=> !dq_oe)
    else $error("read mask latency wrong");
  write_mask_a: assert property (
    cmd == sdr_pkg::CMD_WR && dqm && cke |=> !arr_wr)
    else $error("masked write reached the array");
  single_write_a: assert property (
    (cmd == sdr_pkg::CMD_WR && cke && q_ff.mode[`SDR_WB_BIT])
    ##1 (cke && cmd == sdr_pkg::CMD_NOP) |=> !arr_wr)
    else $error("single-write mode wrote more than one word");
  rd_after_rd_c: cover property (
    cmd == sdr_pkg::CMD_RD ##1 cmd == sdr_pkg::CMD_RD);
  mode_set_c: cover property (cmd == sdr_pkg::CMD_MRS);
  masked_read_c: cover property (out_vld && q_ff.dm[2]);
endmodule : sdr_core
`default_nettype wire

/* File: design/sdr_map.svh */
// Constants of the SDRAM command core: mode field layout and encodings.
// Assumes inclusion by bare name from the design files.
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH
`define SDR_MODE_W    15
`define SDR_MODE_RST  15'h0000
`define SDR_BL_LSB    0
`define SDR_BT_BIT    3
`define SDR_CL_LSB    4
`define SDR_WB_BIT    9
`define SDR_BL_1      3'h0
`define SDR_BL_2      3'h1
`define SDR_BL_4      3'h2
`define SDR_BL_8      3'h3
`define SDR_CL_2      3'h2
`define SDR_CL_3      3'h3
`define SDR_AP_BIT    10
`endif

/* File: design/sdr_pkg.sv */
// Types of the SDRAM command core.
// Assumes nothing beyond a SystemVerilog compiler.
package sdr_pkg;
  // Decoded command, one-hot
  typedef enum logic [6:0]
  {
    CMD_NOP = 7'h01,
    CMD_ACT = 7'h02,
    CMD_RD  = 7'h04,
    CMD_WR  = 7'h08,
    CMD_PRE = 7'h10,
    CMD_MRS = 7'h20,
    CMD_REF = 7'h40
  } sdr_cmd_e;

  // Burst generator state, one-hot
  typedef enum logic [2:0]
  {
    BST_IDLE = 3'h1,
    BST_RD   = 3'h2,
    BST_WR   = 3'h4
  } sdr_bst_e;

  // Data organisation, selects page size
  typedef enum logic [1:0]
  {
    ORG_X4  = 2'h0,
    ORG_X8  = 2'h1,
    ORG_X16 = 2'h2
  } sdr_org_e;

  typedef logic [10:0] sdr_col_t;
endpackage : sdr_pkg

/* File: design/sdr_burst_if.sv */
// Link between the command core and its burst column generator.
// Assumes both ends run on one clock.
`timescale 1ns/1ps
`default_nettype none
interface sdr_burst_if;
  logic             ce;
  logic             go;
  logic             is_wr;
  sdr_pkg::sdr_col_t start;
  logic [3:0]       len;
  logic             ilv;
  sdr_pkg::sdr_col_t col;
  logic             vld;
  logic             wr;
  modport core (output ce, go, is_wr, start, len, ilv, input col, vld, wr);
  modport gen  (input ce, go, is_wr, start, len, ilv, output col, vld, wr);
endinterface : sdr_burst_if
`default_nettype wire

/* File: design/sdr_burst.sv */
// Burst column generator: one column per cycle, sequential or interleave.
// Assumes go is a one-cycle request from the core on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sdr_burst
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Core side
  sdr_burst_if.gen  bif
);
  typedef struct packed
  {
    sdr_pkg::sdr_bst_e st;
    sdr_pkg::sdr_col_t base;
    logic [2:0]        beat;
    logic [3:0]        left;
  } sdr_gen_s;

  sdr_gen_s q_ff;
  sdr_gen_s nxt_q;
  logic [2:0] msk;

  function automatic sdr_pkg::sdr_col_t beat_col
  (
    input sdr_pkg::sdr_col_t base,
    input logic [2:0]        beat,
    input logic [2:0]        m,
    input logic              ilv
  );
    logic [2:0] lo;
    lo = ilv ? (base[2:0] ^ beat) : 3'(base[2:0] + beat);
    beat_col = {base[10:3], (base[2:0] & ~m) | (lo & m)};
  endfunction : beat_col

  assign msk = 3'(q_ff.left + {1'b0, q_ff.beat} - 4'h1);

  // Beat 0 is the start column itself; a new go overrides the old burst
  // restart on command
  always_comb
  begin
    nxt_q = q_ff;
    bif.vld = bif.go || (q_ff.st != sdr_pkg::BST_IDLE);
    bif.wr = bif.go ? bif.is_wr : (q_ff.st == sdr_pkg::BST_WR);
    bif.col = bif.go ? bif.start : beat_col(q_ff.base, q_ff.beat, msk, bif.ilv);
    if (bif.go)
    begin
      nxt_q.base = bif.start;
      nxt_q.beat = 3'h1;
      nxt_q.left = 4'(bif.len - 4'h1);
      nxt_q.st = (bif.len == 4'h1) ? sdr_pkg::BST_IDLE
               : (bif.is_wr ? sdr_pkg::BST_WR : sdr_pkg::BST_RD);
    end
    else if (q_ff.st != sdr_pkg::BST_IDLE)
    begin
      nxt_q.beat = 3'(q_ff.beat + 3'h1);
      nxt_q.left = 4'(q_ff.left - 4'h1);
      if (q_ff.left == 4'h1)
        nxt_q.st = sdr_pkg::BST_IDLE;
    end
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge clk)
  begin
    if (srst)
      q_ff <= '{st: sdr_pkg::BST_IDLE, base: '0, beat: '0, left: '0};
    else if (bif.ce)
      q_ff <= nxt_q;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  burst_length_end_a: assert property (
    (bif.go && bif.ce && bif.len == 4'h4) ##1 (bif.ce && !bif.go)[*3]
    |=> q_ff.st == sdr_pkg::BST_IDLE)
    else $error("length-4 burst did not end after four beats");
  interleave_col_a: assert property (
    (bif.go && bif.ce && bif.ilv && bif.len == 4'h4 && bif.start[1:0] == 2'h1)
    ##1 (bif.ce && !bif.go) |-> bif.col[1:0] == 2'h0
    ##1 (bif.go || !bif.ce || bif.col[1:0] == 2'h3))
    else $error("interleave order wrong");
  sequential_col_a: assert property (
    (bif.go && bif.ce && !bif.ilv && bif.len == 4'h4 && bif.start[1:0] == 2'h3)
    ##1 (bif.ce && !bif.go) |-> bif.col[1:0] == 2'h0)
    else $error("sequential wrap wrong");
  gen_len8_c: cover property (bif.go && bif.len == 4'h8);
endmodule : sdr_burst
`default_nettype wire

/* File: bench/sdr_ctl_model.sv */
// Controller model: drives command, address, mask and write data.
// Assumes the bench calls one task at a time, after reset.
`timescale 1ns/1ps
`default_nettype none
module sdr_ctl_model
#(
  parameter int INIT_CYC = 20000,
  parameter int TRSC     = 2,
  parameter int TRCD     = 2
)
(
  // Clock
  input  wire logic        clk,
  // Pins toward the core
  output var  logic        cke,
  output var  logic [3:0]  cmd_n,
  output var  logic [1:0]  ba,
  output var  logic [12:0] addr,
  output var  logic        dqm,
  output var  logic [15:0] dq
);
  // Idle pins at time zero, mask and clock enable high; data then
  // moves every cycle, so stale data never matches
  initial
  begin
    cke   = 1'b1;
    cmd_n = 4'hF;
    ba    = 2'h0;
    addr  = 13'h0000;
    dqm   = 1'b1;
    dq    = 16'h0000;
    forever
      @(posedge clk) dq <= dq + 16'h0001;
  end

  // Data mask level from the next edge on
  task automatic mask(input logic v);
  begin
    dqm <= v;
  end
  endtask : mask

  // One command for one cycle, then deselect
  task automatic send(input logic [3:0] c, input logic [1:0] b,
                      input logic [12:0] a);
  begin
    @(posedge clk);
    cmd_n <= c;
    ba    <= b;
    addr  <= a;
    @(posedge clk);
    cmd_n <= 4'hF;
    addr  <= ~a;
  end
  endtask : send

  // close all before a new row
  task automatic pre();
  begin
    send(4'h2, 2'h0, 13'h0400);
  end
  endtask : pre

  // open a row, wait; also spaces activates
  task automatic act(input logic [1:0] b, input logic [12:0] r);
  begin
    send(4'h3, b, r);
    repeat (TRCD) @(posedge clk);
  end
  endtask : act

  task automatic mode(input logic [14:0] m);
  begin
    send(4'h0, m[14:13], m[12:0]);
    repeat (TRSC) @(posedge clk);
  end
  endtask : mode

  task automatic init(input logic [14:0] m);
  begin
    repeat (INIT_CYC) @(posedge clk);
    pre();
    send(4'h1, 2'h0, 13'h0000);
    send(4'h1, 2'h0, 13'h0000);
    dqm <= 1'b0;
    mode(m);
  end
  endtask : init
endmodule : sdr_ctl_model
`default_nettype wire

/* File: bench/test_sdram_init_mode_bank_read.sv */
// Bench of the command core: init, modes, bursts, interrupt, writes.
// Assumes the array answers in the cycle from its address.
`timescale 1ns/1ps
`default_nettype none
module test_sdram_init_mode_bank_read;
  logic        clk;
  logic        srst;
  logic        cke;
  logic        dqm;
  logic        dq_oe;
  logic        arr_rd;
  logic        arr_wr;
  logic [3:0]  cmd_n;
  logic [1:0]  ba;
  logic [12:0] addr;
  logic [12:0] arr_row;
  logic [15:0] dq_i;
  sdr_pkg::sdr_org_e org;
  logic [15:0] dq_o;
  logic [1:0]  arr_bank;
  logic [10:0] arr_col;
  logic [15:0] arr_wdata;
  logic [14:0] mode_q;
  logic [3:0]  bank_open;
  wire  [15:0] arr_rdata;
  int          miscompares;
  int          checked;

  // Array data names its own bank and column
  assign arr_rdata = {3'h0, arr_bank, arr_col};

  sdr_ctl_model sdr_ctl_model_inst
  (
    .clk(clk), .cke(cke), .cmd_n(cmd_n), .ba(ba), .addr(addr),
    .dqm(dqm), .dq(dq_i)
  );

  sdr_core sdr_core_inst
  (
    .clk(clk), .srst(srst), .cke(cke), .cs_n(cmd_n[3]),
    .ras_n(cmd_n[2]), .cas_n(cmd_n[1]), .we_n(cmd_n[0]), .ba(ba),
    .addr(addr), .dqm(dqm), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
    .org(org), .arr_bank(arr_bank), .arr_row(arr_row),
    .arr_col(arr_col), .arr_rd(arr_rd), .arr_wr(arr_wr),
    .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .mode_q(mode_q),
    .bank_open(bank_open)
  );

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
  begin
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  end
  endtask : chk

  task automatic results();
  begin
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask : results

  // Column of beat i: wrap in aligned block, or start XOR beat
  function automatic logic [10:0] bcol(input logic [10:0] c, input int i,
                                       input int bl, input logic ilv);
    logic [10:0] m;
  begin
    m = 11'(bl - 1);
    bcol = ilv ? (c ^ (11'(i) & m)) : ((c & ~m) | ((c + 11'(i)) & m));
  end
  endfunction : bcol

  // Read from bank b: beats, then data after cl edges
  task automatic rd_walk(input logic [1:0] b, input logic [10:0] c,
                         input int cl, input int bl, input logic ilv);
    int j;
  begin
    sdr_ctl_model_inst.send(4'h5, b, {2'h0, c});
    for (j = 0; j <= cl + bl; j++)
    begin
      #1;
      chk("arr_rd", 16'(j < bl), 16'(arr_rd));
      if (j < bl)
        chk("arr_col", 16'(bcol(c, j, bl, ilv)), 16'(arr_col));
      chk("dq_oe", 16'(j >= cl && j < cl + bl), 16'(dq_oe));
      if (j >= cl && j < cl + bl)
        chk("dq_o", {3'h0, b, bcol(c, j - cl, bl, ilv)}, dq_o);
      @(posedge clk);
    end
  end
  endtask : rd_walk

  task automatic t_init();
  begin
    #1;
    chk("mode_q", 16'h0000, 16'(mode_q));
    sdr_ctl_model_inst.init(15'h0022);
    chk("mode_q", 16'h0022, 16'(mode_q));
    // Deselected mode set must leave the register alone
    sdr_ctl_model_inst.send(4'h8, 2'h3, 13'h0155);
    @(posedge clk);
    #1;
    chk("mode_q", 16'h0022, 16'(mode_q));
  end
  endtask : t_init

  task automatic t_banks();
    int b;
  begin
    for (b = 0; b < 4; b++)
    begin
      sdr_ctl_model_inst.act(2'(b), 13'h1000 + 13'(b));
      #1;
      chk("bank_open", 16'((1 << (b + 1)) - 1), 16'(bank_open));
    end
    sdr_ctl_model_inst.pre();
    #1;
    chk("bank_open", 16'h0000, 16'(bank_open));
  end
  endtask : t_banks

  // Every latency, length and order, each with a fresh mode set
  task automatic t_modes();
    int cl;
    int k;
    int i;
    logic [14:0] m;
  begin
    for (cl = 2; cl < 4; cl++)
      for (k = 0; k < 4; k++)
        for (i = 0; i < 2; i++)
        begin
          m = {8'h00, 3'(cl), 1'(i), 3'(k)};
          sdr_ctl_model_inst.mode(m);
          chk("mode_q", 16'(m), 16'(mode_q));
          sdr_ctl_model_inst.act(2'h1, 13'h0777);
          rd_walk(2'h1, 11'h005, cl, 1 << k, 1'(i));
          chk("arr_row", 16'h0777, 16'(arr_row));
          sdr_ctl_model_inst.pre();
        end
  end
  endtask : t_modes

  // Second read two edges after the first, latency 3, length 8
  task automatic t_intr();
    int j;
    logic [10:0] c;
  begin
    sdr_ctl_model_inst.mode(15'h0033);
    sdr_ctl_model_inst.act(2'h2, 13'h0100);
    sdr_ctl_model_inst.send(4'h5, 2'h2, 13'h0000);
    fork
      sdr_ctl_model_inst.send(4'h5, 2'h2, 13'h0010);
      for (j = 0; j < 14; j++)
      begin
        #1;
        c = (j < 2) ? 11'(j) : 11'(14 + j);
        chk("arr_rd", 16'(j < 10), 16'(arr_rd));
        if (j < 10)
          chk("arr_col", 16'(c), 16'(arr_col));
        c = (j < 5) ? 11'(j - 3) : 11'(11 + j);
        chk("dq_oe", 16'(j >= 3 && j < 13), 16'(dq_oe));
        if (j >= 3 && j < 13)
          chk("dq_o", {5'h02, c}, dq_o);
        @(posedge clk);
      end
    join
    sdr_ctl_model_inst.pre();
  end
  endtask : t_intr

  // Write of bl beats at column 7, mask high at beat mb, then read back
  task automatic wr_walk(input logic [14:0] m, input int bl, input int mb);
    int j;
    logic [15:0] d0;
  begin
    sdr_ctl_model_inst.mode(m);
    sdr_ctl_model_inst.act(2'h3, 13'h0042);
    sdr_ctl_model_inst.mask(mb == 0);
    sdr_ctl_model_inst.send(4'h4, 2'h3, 13'h0007);
    for (j = 0; j < 6; j++)
    begin
      // Mask set at this edge is taken at the next one
      sdr_ctl_model_inst.mask(j == mb - 1);
      #1;
      if (j == 0)
        d0 = dq_i - 16'h0001;
      chk("arr_wr", 16'(j < bl && j != mb), 16'(arr_wr));
      if (j < bl && j != mb)
      begin
        chk("arr_col", 16'(bcol(11'h007, j, 4, 1'b0)), 16'(arr_col));
        chk("arr_wdata", d0 + 16'(j), arr_wdata);
      end
      @(posedge clk);
    end
    rd_walk(2'h3, 11'h007, int'(m[6:4]), 1 << m[1:0], m[3]);
    sdr_ctl_model_inst.pre();
  end
  endtask : wr_walk

  // Read with mask high at the command edge and the one before it
  task automatic t_rmask();
    int j;
  begin
    sdr_ctl_model_inst.mode(15'h0022);
    sdr_ctl_model_inst.act(2'h0, 13'h0200);
    sdr_ctl_model_inst.mask(1'b1);
    sdr_ctl_model_inst.send(4'h5, 2'h0, 13'h0000);
    sdr_ctl_model_inst.mask(1'b0);
    for (j = 0; j < 7; j++)
    begin
      #1;
      chk("dq_oe", 16'(j >= 3 && j < 6), 16'(dq_oe));
      if (j >= 3 && j < 6)
        chk("dq_o", 16'(j - 2), dq_o);
      @(posedge clk);
    end
    sdr_ctl_model_inst.pre();
  end
  endtask : t_rmask

  // Column bits that each data width drops
  task automatic t_org();
    int o;
    logic [15:0] e;
  begin
    sdr_ctl_model_inst.mode(15'h0020);
    sdr_ctl_model_inst.act(2'h0, 13'h0300);
    for (o = 0; o < 3; o++)
    begin
      org <= sdr_pkg::sdr_org_e'(o);
      sdr_ctl_model_inst.send(4'h5, 2'h0, 13'h0E05);
      #1;
      e = (o == 0) ? 16'h0605 : ((o == 1) ? 16'h0205 : 16'h0005);
      chk("arr_col", e, 16'(arr_col));
      @(posedge clk);
    end
    org <= sdr_pkg::ORG_X4;
    sdr_ctl_model_inst.pre();
  end
  endtask : t_org

  // Main sequence
  initial
  begin
    miscompares = 0;
    checked = 0;
    org = sdr_pkg::ORG_X4;
    srst = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_init();
    t_banks();
    t_modes();
    t_intr();
    t_rmask();
    t_org();
    wr_walk(15'h0223, 1, -1);
    wr_walk(15'h0022, 4, 2);
    wr_walk(15'h0022, 4, 0);
    results();
  end

  // Hang guard, well past the expected run
  initial
  begin
    #400000;
    miscompares++;
    results();
  end
endmodule : test_sdram_init_mode_bank_read
`default_nettype wire
